// file: logic/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_NUM_CELLS 24
`define PMC_NUM_DED 12
`define PMC_NUM_TERMS 10
`define PMC_LOGIC_TERMS 8
`define PMC_PT_CLR 8
`define PMC_PT_OECLK 9
`define PMC_ARRAY_W 72
`define PMC_CLK_PERIOD_NS 10
`define PMC_PD_IDLE_NS 100
`define PMC_PD_IDLE_CYC ((`PMC_PD_IDLE_NS) / (`PMC_CLK_PERIOD_NS))
`define PMC_RD_W 16
`define PMC_RD_NO_OUT 0
`define PMC_RD_FB 1
`define PMC_RD_POL 3
`define PMC_RD_MODE 4
`define PMC_RD_KIND 5
`define PMC_RD_SPLIT 8
`define PMC_REG_RESET 1'b0
`define PMC_OE_N_RESET 1'b1
`endif

// file: logic/pmc_pkg.sv
package pmc_pkg;
   // Register kind of a macrocell; zero is the erased (combinatorial) choice.
   typedef enum logic [2:0] {
      PMC_COMB = 3'h0,
      PMC_DREG = 3'h1,
      PMC_TREG = 3'h2,
      PMC_JKREG = 3'h3,
      PMC_SRREG = 3'h4
   } pmc_kind_e;
   // Feedback source into the AND array; zero is the erased (pin) choice.
   typedef enum logic [1:0] {
      PMC_FB_PIN = 2'h0,
      PMC_FB_REG = 2'h1,
      PMC_FB_NONE = 2'h2
   } pmc_fb_e;
endpackage : pmc_pkg

// file: logic/pmc_cell.sv
`timescale 1ns/100ps
`include "pmc_cfg.svh"
module pmc_cell #(
   parameter int ARRAY_W = `PMC_ARRAY_W
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // AND array signals and static configuration.
   input wire logic [ARRAY_W-1:0] array_vec,
   input wire logic [`PMC_NUM_TERMS*ARRAY_W-1:0] conn,
   input wire logic [2:0] kind,
   input wire logic mode,
   input wire logic pol_high,
   input wire logic [1:0] fb_sel,
   input wire logic no_out,
   input wire logic [`PMC_LOGIC_TERMS-1:0] split,
   // Shared clock edge and synchronised pin level.
   input wire logic sync_rise,
   input wire logic pin_val,
   // Results.
   output logic out_val,
   output logic out_en,
   output logic fb_val,
   output logic reg_q,
   output logic clr_term,
   output logic oeclk_term,
   output logic sum_val,
   output logic tick
);
   logic [`PMC_NUM_TERMS-1:0] term;
   logic or_a;
   logic or_b;
   logic pt_rise;
   logic q_vis;
   logic core;
   logic is_comb;
   logic q_ff;
   logic nxt_q;
   logic ptprev_ff;
   logic nxt_ptprev;
   pmc_pkg::pmc_kind_e kind_e;

   // Each term is an AND of its connected inputs; open inputs are don't care.
   genvar t;
   generate
      for (t = 0; t < `PMC_NUM_TERMS; t++) begin : g_term
         assign term[t] = &(~conn[t*ARRAY_W +: ARRAY_W] | array_vec);
      end
   endgenerate

   // Sum terms: all eight for D, T and combinatorial, split in two for JK and SR.
   assign kind_e = pmc_pkg::pmc_kind_e'(kind);
   assign is_comb = (kind_e == pmc_pkg::PMC_COMB);
   assign sum_val = |term[`PMC_LOGIC_TERMS-1:0];
   assign or_a = |(term[`PMC_LOGIC_TERMS-1:0] & ~split);
   assign or_b = |(term[`PMC_LOGIC_TERMS-1:0] & split);
   assign clr_term = term[`PMC_PT_CLR];
   assign oeclk_term = term[`PMC_PT_OECLK];

   // Register clocking: shared clock in mode 0, rising product term in mode 1.
   assign pt_rise = oeclk_term & ~ptprev_ff;
   assign tick = mode ? pt_rise : sync_rise;

   // Next register state per kind; the clear term overrides everything.
   always_comb begin
      nxt_q = q_ff;
      nxt_ptprev = oeclk_term;
      if (tick) begin
         case (kind_e)
            pmc_pkg::PMC_DREG: nxt_q = sum_val;
            pmc_pkg::PMC_TREG: nxt_q = sum_val ? ~q_ff : q_ff;
            pmc_pkg::PMC_JKREG: begin
               case ({or_a, or_b})
                  2'b10: nxt_q = 1'b1;
                  2'b01: nxt_q = 1'b0;
                  2'b11: nxt_q = ~q_ff;
                  default: nxt_q = q_ff;
               endcase
            end
            pmc_pkg::PMC_SRREG: begin
               case ({or_a, or_b})
                  2'b10: nxt_q = 1'b1;
                  2'b01: nxt_q = 1'b0;
                  2'b11: nxt_q = 1'b0;
                  default: nxt_q = q_ff;
               endcase
            end
            default: nxt_q = 1'b0;
         endcase
      end
      if (clr_term) begin
         nxt_q = 1'b0;
      end
   end

   // Reset stands for power-up and clears the register.
   // The term history follows the term through reset, so a term that is already high
   // at release gives no false clock edge.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q_ff <= `PMC_REG_RESET;
      end else begin
         q_ff <= nxt_q;
      end
      ptprev_ff <= nxt_ptprev;
   end

   // The clear term masks the register output in the same cycle.
   assign q_vis = q_ff & ~clr_term;
   assign reg_q = q_ff;
   assign core = is_comb ? sum_val : q_vis;
   assign out_val = pol_high ? core : ~core;
   assign out_en = ~no_out & ((mode & ~is_comb) | oeclk_term);

   // Feedback uses the raw register so the clear term forms no loop.
   always_comb begin
      case (pmc_pkg::pmc_fb_e'(fb_sel))
         pmc_pkg::PMC_FB_PIN: begin
            fb_val = (kind_e == pmc_pkg::PMC_JKREG || kind_e == pmc_pkg::PMC_SRREG) ?
                     1'b0 : pin_val;
         end
         pmc_pkg::PMC_FB_REG: fb_val = is_comb ? 1'b0 : q_ff;
         default: fb_val = 1'b0;
      endcase
   end
endmodule : pmc_cell

// file: logic/pmc_io_array.sv
`timescale 1ns/100ps
`include "pmc_cfg.svh"
// Operation
// - Mode 0: output enable follows its term
// - Mode 0: register uses its shared clock
// - Erased selector means mode 0
// - Mode 1: registered cells always enabled, term clocks register
// - Term clock from any array input, either edge
// - Clear term forces register low at once
// - Power-up clears every register
// - Combinatorial: eight-term OR, polarity, pin feedback
// - D/T: eight-term OR, polarity, any feedback
// - JK/SR: split terms, register feedback only
// - D loads, T toggles when high
// - No output with pin feedback: input pin
// - Erased cell: combinatorial active low, pin feedback
// - Secure bit blocks readback; erase clears it
// - Inhibit bit disables automatic standby
// - Upper clock cells 13-24, lower 1-12
// - Shared clocks act on rising edge only
// - Ten product terms per cell
// - Open term is high, contradictory term low
module pmc_io_array #(
   parameter int N_CELLS = `PMC_NUM_CELLS,
   parameter int N_DED = `PMC_NUM_DED,
   parameter int PD_IDLE_CYC = `PMC_PD_IDLE_CYC,
   localparam int ARRAY_W = 2 * (N_DED + N_CELLS),
   localparam int IDX_W = $clog2(N_CELLS),
   localparam int TERM_BITS = `PMC_NUM_TERMS * ARRAY_W
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Device pins.
   input wire logic sync_clock_upper,
   input wire logic sync_clock_lower,
   input wire logic [N_DED-1:0] ded_in,
   input wire logic [N_CELLS-1:0] pin_in,
   output logic [N_CELLS-1:0] pin_out,
   output logic [N_CELLS-1:0] pin_oe_n,
   // Static configuration; all zero is the erased state.
   input wire logic [N_CELLS*TERM_BITS-1:0] cfg_conn,
   input wire logic [3*N_CELLS-1:0] cfg_kind,
   input wire logic [N_CELLS-1:0] cfg_mode,
   input wire logic [N_CELLS-1:0] cfg_pol_high,
   input wire logic [2*N_CELLS-1:0] cfg_fb,
   input wire logic [N_CELLS-1:0] cfg_no_out,
   input wire logic [`PMC_LOGIC_TERMS*N_CELLS-1:0] cfg_split,
   // Security bit and readback.
   input wire logic sec_program,
   input wire logic sec_erase,
   input wire logic cfg_rd_req,
   input wire logic [IDX_W-1:0] cfg_rd_idx,
   output logic [`PMC_RD_W-1:0] cfg_rd_data,
   output logic cfg_rd_valid,
   output logic secure,
   // Power-down control and status.
   input wire logic pd_inhibit,
   output logic standby,
   output logic slow_timing
);
   localparam int SYN_W = N_DED + N_CELLS + 2;
   localparam int CNT_W = $clog2(PD_IDLE_CYC + 1);
   localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(PD_IDLE_CYC - 1);

   logic [SYN_W-1:0] sync1_ff;
   logic [SYN_W-1:0] sync2_ff;
   logic [1:0] clkprev_ff;
   logic [N_DED-1:0] ded_s;
   logic [N_CELLS-1:0] pin_s;
   logic rise_up;
   logic rise_lo;
   logic [N_DED+N_CELLS-1:0] src;
   logic [ARRAY_W-1:0] array_vec;
   logic [N_CELLS-1:0] c_out, c_en, c_fb, c_q, c_clr, c_oeclk, c_sum, c_tick, c_rise;
   logic [N_CELLS-1:0] pin_out_ff, pin_oe_n_ff;
   logic secure_ff, nxt_secure;
   logic [`PMC_RD_W-1:0] rd_data_ff, nxt_rd_data;
   logic rd_valid_ff;
   logic [ARRAY_W-1:0] arr_prev_ff;
   logic [CNT_W-1:0] idle_cnt_ff, nxt_idle_cnt;
   logic standby_ff, nxt_standby;
   logic slow_ff;

   // Two-stage synchronisers for every pin input, then clock edge detection.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         clkprev_ff <= 2'h3;
      end else begin
         sync1_ff <= {sync_clock_upper, sync_clock_lower, pin_in, ded_in};
         sync2_ff <= sync1_ff;
         clkprev_ff <= sync2_ff[SYN_W-1 -: 2];
      end
   end
   assign ded_s = sync2_ff[N_DED-1:0];
   assign pin_s = sync2_ff[N_DED +: N_CELLS];
   assign rise_up = sync2_ff[SYN_W-1] & ~clkprev_ff[1];
   assign rise_lo = sync2_ff[SYN_W-2] & ~clkprev_ff[0];

   // Array inputs in true and complement form, then one cell per pin.
   assign src = {c_fb, ded_s};
   genvar i;
   generate
      for (i = 0; i < N_DED + N_CELLS; i++) begin : g_arr
         assign array_vec[2*i] = src[i];
         assign array_vec[2*i+1] = ~src[i];
      end
      for (i = 0; i < N_CELLS; i++) begin : g_cell
         assign c_rise[i] = (i >= N_CELLS / 2) ? rise_up : rise_lo;
         pmc_cell #(.ARRAY_W(ARRAY_W)) u_cell (
            .ref_clk(ref_clk),
            .rst(rst),
            .array_vec(array_vec),
            .conn(cfg_conn[i*TERM_BITS +: TERM_BITS]),
            .kind(cfg_kind[3*i +: 3]),
            .mode(cfg_mode[i]),
            .pol_high(cfg_pol_high[i]),
            .fb_sel(cfg_fb[2*i +: 2]),
            .no_out(cfg_no_out[i]),
            .split(cfg_split[`PMC_LOGIC_TERMS*i +: `PMC_LOGIC_TERMS]),
            .sync_rise(c_rise[i]),
            .pin_val(pin_s[i]),
            .out_val(c_out[i]),
            .out_en(c_en[i]),
            .fb_val(c_fb[i]),
            .reg_q(c_q[i]),
            .clr_term(c_clr[i]),
            .oeclk_term(c_oeclk[i]),
            .sum_val(c_sum[i]),
            .tick(c_tick[i])
         );

         oe_mode0_a: assert property (@(posedge ref_clk) disable iff (rst)
            (!cfg_mode[i] && !cfg_no_out[i]) |=> (pin_oe_n[i] == !$past(c_oeclk[i])))
            else $error("Mode 0 output enable does not follow its term.");
         oe_mode1_a: assert property (@(posedge ref_clk) disable iff (rst)
            (cfg_mode[i] && cfg_kind[3*i +: 3] != 3'h0 && !cfg_no_out[i]) |=> !pin_oe_n[i])
            else $error("Mode 1 output is not driven.");
         clear_now_a: assert property (@(posedge ref_clk) disable iff (rst)
            c_clr[i] |=> (c_q[i] == 1'b0))
            else $error("Clear term did not force the register low.");
         sync_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
            (!cfg_mode[i] && !c_rise[i] && !c_clr[i] && cfg_kind[3*i +: 3] != 3'h0)
            |=> $stable(c_q[i]))
            else $error("Register changed without a shared clock edge.");
         pt_clock_a: assert property (@(posedge ref_clk) disable iff (rst)
            (cfg_mode[i] && $rose(c_oeclk[i])) |-> c_tick[i])
            else $error("Rising clock term did not trigger the register.");
         d_load_a: assert property (@(posedge ref_clk) disable iff (rst)
            (cfg_kind[3*i +: 3] == 3'h1 && c_tick[i] && !c_clr[i]) |=> (c_q[i] == $past(c_sum[i])))
            else $error("D register did not load its input.");
         t_toggle_a: assert property (@(posedge ref_clk) disable iff (rst)
            (cfg_kind[3*i +: 3] == 3'h2 && c_tick[i] && c_sum[i] && !c_clr[i])
            |=> (c_q[i] != $past(c_q[i])))
            else $error("T register did not toggle.");
         comb_low_a: assert property (@(posedge ref_clk) disable iff (rst)
            (cfg_kind[3*i +: 3] == 3'h0 && !cfg_pol_high[i]) |=> (pin_out[i] == !$past(c_sum[i])))
            else $error("Active-low combinatorial output is wrong.");
      end
   endgenerate

   // Pin drivers are registered; the enable is low while the pin is driven.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_out_ff <= '0;
         pin_oe_n_ff <= {N_CELLS{`PMC_OE_N_RESET}};
      end else begin
         pin_out_ff <= c_out;
         pin_oe_n_ff <= ~c_en;
      end
   end
   assign pin_out = pin_out_ff;
   assign pin_oe_n = pin_oe_n_ff;

   power_up_a: assert property (@(posedge ref_clk) rst |=> (c_q == '0))
      else $error("Registers not cleared after reset.");

   // Security bit and readback; erase beats program, readback hides data.
   always_comb begin
      nxt_secure = secure_ff;
      if (sec_program) begin
         nxt_secure = 1'b1;
      end
      if (sec_erase) begin
         nxt_secure = 1'b0;
      end
      nxt_rd_data = '0;
      if (cfg_rd_req && !secure_ff && int'(cfg_rd_idx) < N_CELLS) begin
         nxt_rd_data[`PMC_RD_NO_OUT] = cfg_no_out[cfg_rd_idx];
         nxt_rd_data[`PMC_RD_FB +: 2] = cfg_fb[2*cfg_rd_idx +: 2];
         nxt_rd_data[`PMC_RD_POL] = cfg_pol_high[cfg_rd_idx];
         nxt_rd_data[`PMC_RD_MODE] = cfg_mode[cfg_rd_idx];
         nxt_rd_data[`PMC_RD_KIND +: 3] = cfg_kind[3*cfg_rd_idx +: 3];
         nxt_rd_data[`PMC_RD_SPLIT +: `PMC_LOGIC_TERMS] =
            cfg_split[`PMC_LOGIC_TERMS*cfg_rd_idx +: `PMC_LOGIC_TERMS];
      end
   end

   // Idle counter for automatic standby after a quiet array.
   always_comb begin
      nxt_idle_cnt = idle_cnt_ff;
      nxt_standby = standby_ff;
      if (pd_inhibit || array_vec != arr_prev_ff) begin
         nxt_idle_cnt = '0;
         nxt_standby = 1'b0;
      end else if (idle_cnt_ff >= IDLE_LAST) begin
         nxt_standby = 1'b1;
      end else begin
         nxt_idle_cnt = idle_cnt_ff + CNT_W'(1);
      end
   end

   // Registers for security, readback and power-down.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         secure_ff <= 1'b0;
         rd_data_ff <= '0;
         rd_valid_ff <= 1'b0;
         arr_prev_ff <= '0;
         idle_cnt_ff <= '0;
         standby_ff <= 1'b0;
         slow_ff <= 1'b0;
      end else begin
         secure_ff <= nxt_secure;
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= cfg_rd_req;
         arr_prev_ff <= array_vec;
         idle_cnt_ff <= nxt_idle_cnt;
         standby_ff <= nxt_standby;
         slow_ff <= ~pd_inhibit;
      end
   end
   assign cfg_rd_data = rd_data_ff;
   assign cfg_rd_valid = rd_valid_ff;
   assign secure = secure_ff;
   assign standby = standby_ff;
   assign slow_timing = slow_ff;

   secure_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      (secure_ff && cfg_rd_req) |=> (cfg_rd_data == '0))
      else $error("Configuration returned while secure.");
   erase_clears_a: assert property (@(posedge ref_clk) disable iff (rst)
      sec_erase |=> !secure)
      else $error("Erase did not clear the security bit.");
   no_standby_a: assert property (@(posedge ref_clk) disable iff (rst)
      pd_inhibit |=> !standby)
      else $error("Standby entered while inhibited.");
endmodule : pmc_io_array

// file: testbench/pmc_board.sv
`timescale 1ns/100ps
module pmc_board (
   // Pins of the device.
   input wire logic [23:0] pin_out,
   input wire logic [23:0] pin_oe_n,
   // Board drivers.
   input wire logic [23:0] drv_en,
   input wire logic [23:0] drv_val,
   // Wire level fed back to the device.
   output logic [23:0] pin_in
);
   // The device wins where it drives, then the board; a pull-up holds a free wire high.
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & drv_en & drv_val) | (pin_oe_n & ~drv_en);
endmodule : pmc_board

// file: testbench/pmc_io_array_test.sv
`timescale 1ns/100ps
`include "pmc_cfg.svh"
module pmc_io_array_test;
   localparam logic [71:0] T_LOW = 72'h3;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic sync_clock_upper = 1'b0;
   logic sync_clock_lower = 1'b0;
   logic [11:0] ded_in = 12'h0;
   logic [23:0] pin_in, pin_out, pin_oe_n;
   logic [23:0] drv_en = 24'h0;
   logic [23:0] drv_val = 24'h0;
   logic [17279:0] cfg_conn = '0;
   logic [71:0] cfg_kind = 72'h0;
   logic [23:0] cfg_mode = 24'h0;
   logic [23:0] cfg_pol = 24'h0;
   logic [47:0] cfg_fb = 48'h0;
   logic [23:0] cfg_no_out = 24'h0;
   logic [191:0] cfg_split = 192'h0;
   logic sec_program = 1'b0;
   logic sec_erase = 1'b0;
   logic rd_req = 1'b0;
   logic [4:0] rd_idx = 5'h0;
   logic [15:0] rd_data;
   logic rd_valid, secure, standby, slow_timing;
   logic pd_inhibit = 1'b1;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;

   pmc_io_array #(.PD_IDLE_CYC(2)) u_pmc_io_array (.ref_clk(ref_clk), .rst(rst),
      .sync_clock_upper(sync_clock_upper), .sync_clock_lower(sync_clock_lower),
      .ded_in(ded_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .cfg_conn(cfg_conn), .cfg_kind(cfg_kind), .cfg_mode(cfg_mode), .cfg_pol_high(cfg_pol),
      .cfg_fb(cfg_fb), .cfg_no_out(cfg_no_out), .cfg_split(cfg_split),
      .sec_program(sec_program), .sec_erase(sec_erase), .cfg_rd_req(rd_req),
      .cfg_rd_idx(rd_idx), .cfg_rd_data(rd_data), .cfg_rd_valid(rd_valid), .secure(secure),
      .pd_inhibit(pd_inhibit), .standby(standby), .slow_timing(slow_timing));

   pmc_board u_pmc_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drv_en(drv_en),
      .drv_val(drv_val), .pin_in(pin_in));

   // Clock generator.
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   // Watchdog against a hung run.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         end_of_test();
      end
   end

   // Prints the verdict and stops.
   task automatic end_of_test();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   // Compares one value and records any mismatch.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Covers the two-stage input sync plus the output register.
   task automatic settle();
      repeat (5) @(negedge ref_clk);
   endtask : settle

   // Single-literal term on one array source, true or complement.
   function automatic logic [71:0] tv(input int src, input int comp);
      return 72'h1 << (2 * src + comp);
   endfunction : tv

   // Configures a cell with every term low except an open enable term.
   task automatic setup(input int c, input logic [2:0] k, input logic m, input logic p,
         input logic [1:0] f, input logic n, input logic [7:0] s);
      @(negedge ref_clk);
      cfg_kind[3*c+:3] = k;
      cfg_mode[c] = m;
      cfg_pol[c] = p;
      cfg_fb[2*c+:2] = f;
      cfg_no_out[c] = n;
      cfg_split[8*c+:8] = s;
      for (int t = 0; t < 9; t++) cfg_conn[c*720+t*72+:72] = T_LOW;
      cfg_conn[c*720+648+:72] = 72'h0;
   endtask : setup

   // Rising then falling edge on one shared clock pin.
   task automatic pulse(input bit up);
      if (up) sync_clock_upper = 1'b1;
      else sync_clock_lower = 1'b1;
      settle();
      sync_clock_upper = 1'b0;
      sync_clock_lower = 1'b0;
      settle();
   endtask : pulse

   // One readback request and its one-cycle answer.
   task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
      rd_req = 1'b1;
      rd_idx = idx;
      @(negedge ref_clk);
      rd_req = 1'b0;
      check("rd_valid", {15'h0, rd_valid}, 16'h1);
      check("rd_data", rd_data, exp);
      @(negedge ref_clk);
      check("rd_valid low", {15'h0, rd_valid}, 16'h0);
   endtask : rd

   // Combinatorial path, enable term, polarity and erased defaults.
   task automatic t_comb();
      check("erased oe_n", {15'h0, pin_oe_n[5]}, 16'h0);
      check("erased out", {15'h0, pin_out[5]}, 16'h0);
      setup(0, pmc_pkg::PMC_COMB, 1'b0, 1'b0, pmc_pkg::PMC_FB_PIN, 1'b0, 8'h0);
      cfg_conn[0+:72] = tv(0, 0);
      cfg_conn[648+:72] = tv(1, 0);
      settle();
      check("oe off", {15'h0, pin_oe_n[0]}, 16'h1);
      ded_in[1:0] = 2'h3;
      settle();
      check("oe on", {15'h0, pin_oe_n[0]}, 16'h0);
      check("active low", {15'h0, pin_out[0]}, 16'h0);
      ded_in[0] = 1'b0;
      settle();
      check("sum low", {15'h0, pin_out[0]}, 16'h1);
      cfg_pol[0] = 1'b1;
      settle();
      check("pol high", {15'h0, pin_out[0]}, 16'h0);
   endtask : t_comb

   // Shared clocks, D and T behaviour, clear term.
   task automatic t_sync();
      setup(0, pmc_pkg::PMC_DREG, 1'b0, 1'b1, pmc_pkg::PMC_FB_REG, 1'b0, 8'h0);
      setup(12, pmc_pkg::PMC_DREG, 1'b0, 1'b1, pmc_pkg::PMC_FB_REG, 1'b0, 8'h0);
      cfg_conn[0+:72] = tv(0, 0);
      cfg_conn[576+:72] = tv(2, 0);
      cfg_conn[8640+:72] = tv(0, 0);
      cfg_conn[9216+:72] = tv(2, 0);
      ded_in = 12'h001;
      settle();
      check("no clock", {15'h0, pin_out[0]}, 16'h0);
      sync_clock_lower = 1'b1;
      settle();
      check("lower d", {15'h0, pin_out[0]}, 16'h1);
      check("upper idle", {15'h0, pin_out[12]}, 16'h0);
      sync_clock_upper = 1'b1;
      settle();
      check("upper d", {15'h0, pin_out[12]}, 16'h1);
      ded_in[0] = 1'b0;
      settle();
      sync_clock_upper = 1'b0;
      sync_clock_lower = 1'b0;
      settle();
      check("fall ignored", {15'h0, pin_out[0]}, 16'h1);
      cfg_kind[2:0] = pmc_pkg::PMC_TREG;
      ded_in[0] = 1'b1;
      pulse(1'b0);
      check("toggle 0", {15'h0, pin_out[0]}, 16'h0);
      pulse(1'b0);
      check("toggle 1", {15'h0, pin_out[0]}, 16'h1);
      ded_in[0] = 1'b0;
      pulse(1'b0);
      check("t hold", {15'h0, pin_out[0]}, 16'h1);
      ded_in[2] = 1'b1;
      settle();
      check("clear", {15'h0, pin_out[0]}, 16'h0);
      check("clear up", {15'h0, pin_out[12]}, 16'h0);
      ded_in[2] = 1'b0;
   endtask : t_sync

   // Term clock on a falling input and a second reset.
   task automatic t_async();
      setup(0, pmc_pkg::PMC_DREG, 1'b1, 1'b1, pmc_pkg::PMC_FB_REG, 1'b0, 8'h0);
      cfg_conn[0+:72] = tv(0, 0);
      cfg_conn[648+:72] = tv(3, 1);
      ded_in = 12'h009;
      settle();
      check("mode1 oe", {15'h0, pin_oe_n[0]}, 16'h0);
      check("mode1 idle", {15'h0, pin_out[0]}, 16'h0);
      ded_in[3] = 1'b0;
      settle();
      check("term clock", {15'h0, pin_out[0]}, 16'h1);
      ded_in[0] = 1'b0;
      pulse(1'b0);
      check("sync ignored", {15'h0, pin_out[0]}, 16'h1);
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("reset out", {15'h0, pin_out[0]}, 16'h0);
      check("reset oe", {8'h0, pin_oe_n[7:0]}, 16'h00ff);
      rst = 1'b0;
      settle();
   endtask : t_async

   // JK and SR split terms, then readback and security.
   task automatic t_split();
      logic [2:0] k;
      for (int i = 0; i < 2; i++) begin
         k = (i == 0) ? pmc_pkg::PMC_JKREG : pmc_pkg::PMC_SRREG;
         setup(0, k, 1'b0, 1'b1, pmc_pkg::PMC_FB_REG, 1'b0, 8'h02);
         cfg_conn[0+:72] = tv(0, 0);
         cfg_conn[72+:72] = tv(1, 0);
         ded_in = 12'h001;
         pulse(1'b0);
         check("set", {15'h0, pin_out[0]}, 16'h1);
         ded_in = 12'h002;
         pulse(1'b0);
         check("reset", {15'h0, pin_out[0]}, 16'h0);
         ded_in = 12'h003;
         pulse(1'b0);
         check("both", {15'h0, pin_out[0]}, (i == 0) ? 16'h1 : 16'h0);
      end
      rd(5'h00, {8'h02, 3'h4, 1'b0, 1'b1, 2'h1, 1'b0});
      rd(5'h18, 16'h0);
      sec_program = 1'b1;
      @(negedge ref_clk);
      sec_program = 1'b0;
      @(negedge ref_clk);
      check("secure", {15'h0, secure}, 16'h1);
      rd(5'h00, 16'h0);
      sec_erase = 1'b1;
      @(negedge ref_clk);
      sec_erase = 1'b0;
      @(negedge ref_clk);
      check("erased", {15'h0, secure}, 16'h0);
   endtask : t_split

   // Pin used purely as an input, read through another cell.
   task automatic t_input();
      setup(0, pmc_pkg::PMC_COMB, 1'b0, 1'b1, pmc_pkg::PMC_FB_PIN, 1'b1, 8'h0);
      setup(1, pmc_pkg::PMC_COMB, 1'b0, 1'b1, pmc_pkg::PMC_FB_PIN, 1'b0, 8'h0);
      cfg_conn[720+:72] = tv(12, 0);
      drv_en[0] = 1'b1;
      drv_val[0] = 1'b1;
      settle();
      check("input hi-z", {15'h0, pin_oe_n[0]}, 16'h1);
      check("pin seen 1", {15'h0, pin_out[1]}, 16'h1);
      drv_val[0] = 1'b0;
      settle();
      check("pin seen 0", {15'h0, pin_out[1]}, 16'h0);
      drv_val[0] = 1'b1;
      cfg_fb[1:0] = pmc_pkg::PMC_FB_NONE;
      settle();
      check("no feedback", {15'h0, pin_out[1]}, 16'h0);
   endtask : t_input

   // Automatic standby and its inhibit.
   task automatic t_standby();
      pd_inhibit = 1'b0;
      repeat (8) @(negedge ref_clk);
      check("standby", {14'h0, standby, slow_timing}, 16'h3);
      pd_inhibit = 1'b1;
      settle();
      check("inhibit", {14'h0, standby, slow_timing}, 16'h0);
   endtask : t_standby

   // Main sequence.
   initial begin
      repeat (7) @(negedge ref_clk);
      check("rst out", pin_out[15:0], 16'h0);
      check("rst oe", pin_oe_n[15:0], 16'hffff);
      check("rst st", {13'h0, secure, standby, slow_timing}, 16'h0);
      @(negedge ref_clk);
      rst = 1'b0;
      settle();
      t_comb();
      t_sync();
      t_async();
      t_split();
      t_input();
      t_standby();
      end_of_test();
   end
endmodule : pmc_io_array_test
